// ==== rtl/uesu_outcome_mem.sv ====
// Purpose: per-endpoint store of the last transaction outcome byte
// Assumes: one write and one read port, read data registered
// Notes:   all words read zero after reset
`timescale 1ns/1ps
module uesu_outcome_mem #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 8,
   parameter int AW    = 4
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data_q
);

   // ***********************************************************
   // storage
   // ***********************************************************
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         rd_data_q <= '0;
      end else begin
         if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
         end
         rd_data_q <= mem_q[rd_addr];
      end
   end

endmodule : uesu_outcome_mem

// ==== rtl/uesu_pkg.sv ====
// Purpose: shared constants for the endpoint status, setup and unlock logic
// Assumes: 8-bit command/data port, command phase marked by bus_a0 high
// Notes:   opcodes split into a high nibble (command group) and low nibble (endpoint)
package uesu_pkg;

   // ***********************************************************
   // command groups and fixed opcodes
   // ***********************************************************
   localparam logic [3:0] GRP_CHECK     = 4'hd;
   localparam logic [3:0] GRP_STATUS    = 4'h5;
   localparam logic [3:0] GRP_OUTCOME   = 4'ha;
   localparam logic [3:0] GRP_VALIDATE  = 4'h6;
   localparam logic [3:0] GRP_CLEAR     = 4'h7;
   localparam logic [7:0] CMD_SETUP_ACK = 8'hf4;
   localparam logic [7:0] CMD_UNLOCK    = 8'hb0;

   // ***********************************************************
   // endpoint indices and unlock code
   // ***********************************************************
   localparam logic [3:0] EP_CTL_OUT    = 4'h0;
   localparam logic [3:0] EP_CTL_IN     = 4'h1;
   localparam logic [7:0] UNLOCK_LO     = 8'h37;
   localparam logic [7:0] UNLOCK_HI     = 8'haa;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int ST_STALL_BIT   = 7;
   localparam int ST_FULL1_BIT   = 6;
   localparam int ST_FULL0_BIT   = 5;
   localparam int ST_TOGGLE_BIT  = 4;
   localparam int ST_OWRITE_BIT  = 3;
   localparam int ST_SETUP_BIT   = 2;
   localparam int ST_BUFSEL_BIT  = 1;
   localparam int OC_MISSED_BIT  = 7;
   localparam int OC_TOGGLE_BIT  = 6;
   localparam int OC_ERR_LSB     = 1;
   localparam int OC_OK_BIT      = 0;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic       RST_LOCKED = 1'b0;

   // ***********************************************************
   // command phase states
   // ***********************************************************
   typedef enum logic [5:0] {
      ST_IDLE       = 6'h01,
      ST_UNLOCK_LO  = 6'h02,
      ST_UNLOCK_HI  = 6'h04,
      ST_RD_CHECK   = 6'h08,
      ST_RD_STATUS  = 6'h10,
      ST_RD_OUTCOME = 6'h20
   } uesu_state_type;

endpackage : uesu_pkg

// ==== rtl/uesu_top.sv ====
// Purpose: endpoint status check, setup acknowledge, transaction outcome and unlock
// Assumes: command write with bus_a0 high, data phase with bus_a0 low, 8-bit bus
// Notes:   leave one idle cycle between a read command and its data read
//
// Overview of operation
// - D0-DF check status, one byte, clears only D0 bit 3
// - bits 7,6,5: stalled, secondary full, primary full
// - bit 4 gives next expected data toggle
// - bit 3 flags overwritten setup, read clears
// - bit 2 setup present, bit 1 buffer select
// - setup blocks control validate and clear commands
// - F4 acknowledge re-enables control buffer commands
// - A0-AF returns last outcome, each transaction replaces
// - outcome bit 7 set when previous outcome_missed
// - outcome bit 6 holds last data toggle
// - bits 4:1 error code, bit 0 success
// - error codes 0000 to 0011 as defined
// - error codes 0100 to 1001 as defined
// - error codes 1010 to 1111 as defined
// - suspend protects; after resume locked until unlock
// - clearing status read clears endpoint interrupt flag
// - lower byte 37h; AA37h unlocks everything
`timescale 1ns/1ps
module uesu_top #(
   parameter int NUM_EP = 16
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic              bus_a0,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   input  wire logic [7:0]        bus_wdata,
   output logic      [7:0]        bus_rdata_q,
   output logic                   bus_rvalid_q,
   input  wire logic [NUM_EP-1:0] ep_stalled,
   input  wire logic [NUM_EP-1:0] secondary_buf_full,
   input  wire logic [NUM_EP-1:0] primary_buf_full,
   input  wire logic [NUM_EP-1:0] next_toggle,
   input  wire logic [NUM_EP-1:0] setup_present,
   input  wire logic [NUM_EP-1:0] host_side_buf_sel,
   input  wire logic              setup_rx,
   input  wire logic              setup_writing,
   input  wire logic              xact_done,
   input  wire logic [3:0]        xact_ep,
   input  wire logic              xact_ok,
   input  wire logic [3:0]        xact_err,
   input  wire logic              xact_toggle,
   input  wire logic              suspended,
   output logic                   write_protect_q,
   output logic                   ctl_cmds_blocked_q,
   output logic                   buf_validate_q,
   output logic                   buf_clear_q,
   output logic [3:0]             buf_cmd_ep_q,
   output logic                   setup_ack_q,
   output logic                   int_clear_q,
   output logic [3:0]             int_clear_ep_q
);

   // ***********************************************************
   // declarations
   // ***********************************************************
   uesu_pkg::uesu_state_type state_q, state_d;
   logic [3:0]        cmd_ep_q, cmd_ep_d;
   logic              ow_q, ow_d;
   logic [NUM_EP-1:0] outcome_missed_q, outcome_missed_d;
   logic              locked_d, block_d;
   logic [7:0]        rdata_d;
   logic              rvalid_d, validate_d, clear_d, ack_d, intclr_d;
   logic [3:0]        intclr_ep_d;
   logic              cmd_fire, data_wr, data_rd;
   logic [3:0]        grp, sel;
   logic [7:0]        check_byte, mem_rdata, xact_byte;
   logic              oc_read_same, xact_missed;

   assign cmd_fire = bus_wr && bus_a0;
   assign data_wr  = bus_wr && !bus_a0;
   assign data_rd  = bus_rd && !bus_a0;
   assign grp      = bus_wdata[7:4];
   assign sel      = bus_wdata[3:0];

   // ***********************************************************
   // status image
   // ***********************************************************
   // live status byte
   always_comb begin
      check_byte = uesu_pkg::RST_BYTE;
      check_byte[uesu_pkg::ST_STALL_BIT]  = ep_stalled[cmd_ep_q];
      check_byte[uesu_pkg::ST_FULL1_BIT]  = secondary_buf_full[cmd_ep_q];
      check_byte[uesu_pkg::ST_FULL0_BIT]  = primary_buf_full[cmd_ep_q];
      check_byte[uesu_pkg::ST_TOGGLE_BIT] = next_toggle[cmd_ep_q];
      check_byte[uesu_pkg::ST_OWRITE_BIT] = ow_q && (cmd_ep_q == uesu_pkg::EP_CTL_OUT);
      check_byte[uesu_pkg::ST_SETUP_BIT]  = setup_present[cmd_ep_q];
      check_byte[uesu_pkg::ST_BUFSEL_BIT] = host_side_buf_sel[cmd_ep_q];
   end

   // ***********************************************************
   // transaction outcome
   // ***********************************************************
   assign oc_read_same = data_rd && (state_q == uesu_pkg::ST_RD_OUTCOME) && !write_protect_q
                         && (cmd_ep_q == xact_ep);
   assign xact_missed  = outcome_missed_q[xact_ep] && !oc_read_same;

   always_comb begin
      xact_byte = uesu_pkg::RST_BYTE;
      xact_byte[uesu_pkg::OC_MISSED_BIT] = xact_missed;
      xact_byte[uesu_pkg::OC_TOGGLE_BIT] = xact_toggle;
      xact_byte[uesu_pkg::OC_ERR_LSB +: 4] = xact_err;
      xact_byte[uesu_pkg::OC_OK_BIT] = xact_ok;
   end

   uesu_outcome_mem #(
      .DEPTH (NUM_EP),
      .WIDTH (8),
      .AW    (4)
   ) u_outcome_mem (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .wr_en     (xact_done),
      .wr_addr   (xact_ep),
      .wr_data   (xact_byte),
      .rd_addr   (cmd_ep_q),
      .rd_data_q (mem_rdata)
   );

   // ***********************************************************
   // command interpreter
   // ***********************************************************
   always_comb begin
      state_d     = state_q;
      cmd_ep_d    = cmd_ep_q;
      ow_d        = ow_q;
      outcome_missed_d    = outcome_missed_q;
      locked_d    = write_protect_q;
      block_d     = ctl_cmds_blocked_q;
      rdata_d     = bus_rdata_q;
      rvalid_d    = 1'b0;
      validate_d  = 1'b0;
      clear_d     = 1'b0;
      ack_d       = 1'b0;
      intclr_d    = 1'b0;
      intclr_ep_d = int_clear_ep_q;
      if (cmd_fire) begin
         cmd_ep_d = sel;
         state_d  = uesu_pkg::ST_IDLE;
         if (bus_wdata == uesu_pkg::CMD_UNLOCK) begin
            state_d = uesu_pkg::ST_UNLOCK_LO;
         end else if (!write_protect_q) begin
            if (grp == uesu_pkg::GRP_CHECK) begin
               state_d = uesu_pkg::ST_RD_CHECK;
            end else if (grp == uesu_pkg::GRP_STATUS) begin
               state_d = uesu_pkg::ST_RD_STATUS;
            end else if (grp == uesu_pkg::GRP_OUTCOME) begin
               state_d = uesu_pkg::ST_RD_OUTCOME;
            end else if (grp == uesu_pkg::GRP_VALIDATE) begin
               validate_d = (sel != uesu_pkg::EP_CTL_OUT)
                            && !(ctl_cmds_blocked_q && sel == uesu_pkg::EP_CTL_IN);
            end else if (grp == uesu_pkg::GRP_CLEAR) begin
               clear_d = (sel != uesu_pkg::EP_CTL_IN)
                         && !(ctl_cmds_blocked_q && sel == uesu_pkg::EP_CTL_OUT);
            end else if (bus_wdata == uesu_pkg::CMD_SETUP_ACK) begin
               ack_d   = 1'b1;
               block_d = 1'b0;
            end
         end
      end
      if (data_wr) begin
         state_d = uesu_pkg::ST_IDLE;
         if (state_q == uesu_pkg::ST_UNLOCK_LO && bus_wdata == uesu_pkg::UNLOCK_LO) begin
            state_d = uesu_pkg::ST_UNLOCK_HI;
         end
         if (state_q == uesu_pkg::ST_UNLOCK_HI && bus_wdata == uesu_pkg::UNLOCK_HI) begin
            locked_d = 1'b0;
         end
      end
      if (data_rd) begin
         rvalid_d = 1'b1;
         rdata_d  = uesu_pkg::RST_BYTE;
         state_d  = uesu_pkg::ST_IDLE;
         if (!write_protect_q) begin
            if (state_q == uesu_pkg::ST_RD_CHECK || state_q == uesu_pkg::ST_RD_STATUS) begin
               rdata_d = check_byte;
               if (cmd_ep_q == uesu_pkg::EP_CTL_OUT && !setup_writing) begin
                  ow_d = 1'b0;
               end
            end
            if (state_q == uesu_pkg::ST_RD_STATUS) begin
               intclr_d    = 1'b1;
               intclr_ep_d = cmd_ep_q;
            end
            if (state_q == uesu_pkg::ST_RD_OUTCOME) begin
               rdata_d            = mem_rdata;
               outcome_missed_d[cmd_ep_q] = 1'b0;
            end
         end
      end
      // setup arrival blocks; setup_overwritten set wins
      if (setup_rx) begin
         block_d = 1'b1;
         if (ctl_cmds_blocked_q && setup_present[0] && !ep_stalled[0]) begin
            ow_d = 1'b1;
         end
      end
      if (xact_done) begin
         outcome_missed_d[xact_ep] = 1'b1;
      end
      if (suspended) begin
         locked_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q            <= uesu_pkg::ST_IDLE;
         cmd_ep_q           <= '0;
         ow_q               <= 1'b0;
         outcome_missed_q           <= '0;
         write_protect_q    <= uesu_pkg::RST_LOCKED;
         ctl_cmds_blocked_q <= 1'b0;
         bus_rdata_q        <= uesu_pkg::RST_BYTE;
         bus_rvalid_q       <= 1'b0;
         buf_validate_q     <= 1'b0;
         buf_clear_q        <= 1'b0;
         buf_cmd_ep_q       <= '0;
         setup_ack_q        <= 1'b0;
         int_clear_q        <= 1'b0;
         int_clear_ep_q     <= '0;
      end else begin
         state_q            <= state_d;
         cmd_ep_q           <= cmd_ep_d;
         ow_q               <= ow_d;
         outcome_missed_q           <= outcome_missed_d;
         write_protect_q    <= locked_d;
         ctl_cmds_blocked_q <= block_d;
         bus_rdata_q        <= rdata_d;
         bus_rvalid_q       <= rvalid_d;
         buf_validate_q     <= validate_d;
         buf_clear_q        <= clear_d;
         buf_cmd_ep_q       <= cmd_ep_d;
         setup_ack_q        <= ack_d;
         int_clear_q        <= intclr_d;
         int_clear_ep_q     <= intclr_ep_d;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_check_no_clear: assert property (
      data_rd && state_q == uesu_pkg::ST_RD_CHECK |=> bus_rvalid_q && !int_clear_q)
      else $error("check read cleared interrupt");

   chk_check_byte_live: assert property (
      data_rd && state_q == uesu_pkg::ST_RD_CHECK && !write_protect_q
      |=> bus_rdata_q == $past(check_byte) && bus_rdata_q[0] == 1'b0)
      else $error("check byte differs from live status");

   chk_setup_overwritten_set: assert property (
      setup_rx && ctl_cmds_blocked_q && setup_present[0] && !ep_stalled[0]
      |=> ow_q)
      else $error("setup_overwritten flag not set");

   chk_setup_blocks: assert property (
      cmd_fire && bus_wdata == {uesu_pkg::GRP_CLEAR, uesu_pkg::EP_CTL_OUT}
      && ctl_cmds_blocked_q |=> !buf_clear_q)
      else $error("clear accepted while setup pending");

   chk_ack_unblocks: assert property (
      cmd_fire && bus_wdata == uesu_pkg::CMD_SETUP_ACK && !write_protect_q && !setup_rx
      |=> setup_ack_q && !ctl_cmds_blocked_q)
      else $error("acknowledge did not unblock");

   chk_outcome_missed_marks: assert property (
      xact_done && outcome_missed_q[xact_ep] && !oc_read_same
      |=> u_outcome_mem.mem_q[$past(xact_ep)][uesu_pkg::OC_MISSED_BIT])
      else $error("missed outcome not flagged");

   chk_locked_reads: assert property (
      write_protect_q && data_rd |=> bus_rvalid_q && bus_rdata_q == 8'h00)
      else $error("read allowed while locked");

   chk_suspend_locks: assert property (
      suspended |=> write_protect_q [*1] ##1 (write_protect_q || !$past(suspended)))
      else $error("suspend did not protect");

   chk_bad_unlock: assert property (
      write_protect_q && data_wr && state_q == uesu_pkg::ST_UNLOCK_HI
      && bus_wdata != uesu_pkg::UNLOCK_HI |=> write_protect_q)
      else $error("wrong code unlocked device");

   chk_good_unlock: assert property (
      state_q == uesu_pkg::ST_UNLOCK_HI && data_wr && bus_wdata == uesu_pkg::UNLOCK_HI
      && !suspended |=> !write_protect_q)
      else $error("correct code did not unlock");

   chk_status_int_clear: assert property (
      data_rd && state_q == uesu_pkg::ST_RD_STATUS && !write_protect_q
      |=> int_clear_q && int_clear_ep_q == $past(cmd_ep_q))
      else $error("clearing read missed interrupt clear");

endmodule : uesu_top

// ==== tb/uesu_host_model.sv ====
// Purpose: local microcontroller on the command/data port
// Assumes: strobes change 5 ns after the rising edge, one byte per strobe
// Notes:   write data idles at the inverse of the last byte
`timescale 1ns/1ps
module uesu_host_model (
   input  wire logic       core_clk,
   output logic            bus_a0,
   output logic            bus_wr,
   output logic            bus_rd,
   output logic [7:0]      bus_wdata,
   input  wire logic [7:0] bus_rdata_q,
   input  wire logic       bus_rvalid_q
);
   localparam int DLY = 5;
   initial begin
      bus_a0 = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end
   // ***********************************************************
   // bus cycles
   // ***********************************************************
   task put(input logic a0, input logic [7:0] d);
      @(posedge core_clk) #DLY;
      bus_a0 = a0;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(posedge core_clk) #DLY;
      bus_wr = 1'b0;
      bus_wdata = ~d;
   endtask : put
   task get(output logic [7:0] d);
      int n;
      @(posedge core_clk) #DLY;
      bus_a0 = 1'b0;
      bus_rd = 1'b1;
      @(posedge core_clk) #DLY;
      bus_rd = 1'b0;
      for (n = 0; n < 3 && bus_rvalid_q !== 1'b1; n++) begin
         @(posedge core_clk) #1;
      end
      d = bus_rdata_q;
   endtask : get
   task query(input logic [7:0] code, output logic [7:0] d);
      put(1'b1, code);
      get(d);
   endtask : query
   task unlock(input logic [7:0] first, input logic [7:0] second);
      put(1'b1, uesu_pkg::CMD_UNLOCK);
      put(1'b0, first);
      put(1'b0, second);
   endtask : unlock
   task ack_setup(output logic done);
      logic [7:0] s;
      query(8'hd0, s);
      done = ~s[uesu_pkg::ST_OWRITE_BIT];
      if (done) begin
         put(1'b1, uesu_pkg::CMD_SETUP_ACK);
      end
   endtask : ack_setup
endmodule : uesu_host_model

// ==== tb/usb_endpoint_status_error_unlock_test.sv ====
// Purpose: self-checking bench for status check, setup ack, outcome and unlock
// Assumes: inputs change 5 ns after the rising edge
// Notes:   pulse outputs are counted on every rising edge
`timescale 1ns/1ps
module usb_endpoint_status_error_unlock_test;
   localparam int DLY = 5;
   logic        core_clk, rst_b, bus_a0, bus_wr, bus_rd, bus_rvalid_q;
   logic [7:0]  bus_wdata, bus_rdata_q, b;
   logic [15:0] ep_stalled, secondary_buf_full, primary_buf_full;
   logic [15:0] next_toggle, setup_present, host_side_buf_sel;
   logic        setup_rx, setup_writing, xact_done, xact_ok, xact_toggle, suspended;
   logic [3:0]  xact_ep, xact_err, buf_cmd_ep_q, int_clear_ep_q;
   logic        write_protect_q, ctl_cmds_blocked_q, buf_validate_q, buf_clear_q;
   logic        setup_ack_q, int_clear_q, done;
   int          miscompares, checks, n_val, n_clr, n_ack, n_int;
   uesu_top uut (.core_clk(core_clk), .rst_b(rst_b), .bus_a0(bus_a0), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
      .bus_rvalid_q(bus_rvalid_q), .ep_stalled(ep_stalled),
      .secondary_buf_full(secondary_buf_full), .primary_buf_full(primary_buf_full),
      .next_toggle(next_toggle), .setup_present(setup_present),
      .host_side_buf_sel(host_side_buf_sel), .setup_rx(setup_rx),
      .setup_writing(setup_writing), .xact_done(xact_done), .xact_ep(xact_ep),
      .xact_ok(xact_ok), .xact_err(xact_err), .xact_toggle(xact_toggle),
      .suspended(suspended), .write_protect_q(write_protect_q),
      .ctl_cmds_blocked_q(ctl_cmds_blocked_q), .buf_validate_q(buf_validate_q),
      .buf_clear_q(buf_clear_q), .buf_cmd_ep_q(buf_cmd_ep_q), .setup_ack_q(setup_ack_q),
      .int_clear_q(int_clear_q), .int_clear_ep_q(int_clear_ep_q));
   uesu_host_model host (.core_clk(core_clk), .bus_a0(bus_a0), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
      .bus_rvalid_q(bus_rvalid_q));
   // ***********************************************************
   // clock, pulse counters, helpers
   // ***********************************************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (buf_validate_q === 1'b1) n_val++;
      if (buf_clear_q === 1'b1) n_clr++;
      if (setup_ack_q === 1'b1) n_ack++;
      if (int_clear_q === 1'b1) n_int++;
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task wrap_up;
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task settle;
      repeat (2) @(posedge core_clk);
      #DLY;
   endtask : settle
   task pulse_setup;
      @(posedge core_clk) #DLY setup_rx = 1'b1;
      @(posedge core_clk) #DLY setup_rx = 1'b0;
   endtask : pulse_setup
   task xact(input logic [3:0] ep, input logic [3:0] err, input logic ok, input logic tg);
      @(posedge core_clk) #DLY;
      {xact_ep, xact_err, xact_ok, xact_toggle, xact_done} = {ep, err, ok, tg, 1'b1};
      @(posedge core_clk) #DLY xact_done = 1'b0;
   endtask : xact
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task t_status;
      host.query(8'hd0, b);
      check(bus_rvalid_q, 1'b1);
      check(b, 8'h00);
      {ep_stalled[3], secondary_buf_full[3], primary_buf_full[3]} = 3'b101;
      {next_toggle[3], setup_present[3], host_side_buf_sel[3]} = 3'b101;
      {ep_stalled[2], secondary_buf_full[2], primary_buf_full[2], next_toggle[2]} = 4'hf;
      {setup_present[2], host_side_buf_sel[2]} = 2'b11;
      host.query(8'hd3, b);
      check(b, 8'hb2);
      host.query(8'hd2, b);
      check(b, 8'hf6);
      settle();
      check(n_int, 0);
      host.query(8'h53, b);
      settle();
      check(b, 8'hb2);
      check(n_int, 1);
      check(int_clear_ep_q, 4'h3);
      next_toggle[3] = 1'b0;
      host.query(8'hd3, b);
      check(b, 8'ha2);
   endtask : t_status
   task t_setup;
      setup_present[0] = 1'b1;
      setup_writing = 1'b1;
      pulse_setup();
      pulse_setup();
      host.query(8'hd0, b);
      check(b, 8'h0c);
      setup_writing = 1'b0;
      host.ack_setup(done);
      check(done, 1'b0);
      host.put(1'b1, 8'h61);
      host.put(1'b1, 8'h70);
      settle();
      check({ctl_cmds_blocked_q, 8'(n_val), 8'(n_clr)}, 17'h10000);
      host.ack_setup(done);
      settle();
      check({done, ctl_cmds_blocked_q, 8'(n_ack)}, 10'h201);
      host.put(1'b1, 8'h61);
      check(buf_cmd_ep_q, 4'h1);
      host.put(1'b1, 8'h70);
      settle();
      check({8'(n_val), 8'(n_clr)}, 16'h0101);
   endtask : t_setup
   task t_outcome;
      for (int i = 0; i < 16; i++) begin
         xact(4'h5, 4'(i), i == 0, i[0]);
         host.query(8'ha5, b);
         check(b, {1'b0, i[0], 1'b0, 4'(i), i == 0});
      end
      xact(4'h5, 4'h9, 1'b0, 1'b1);
      xact(4'h5, 4'hf, 1'b0, 1'b1);
      host.query(8'ha5, b);
      check(b, 8'hde);
      host.query(8'ha6, b);
      check(b, 8'h00);
   endtask : t_outcome
   task t_unlock;
      suspended = 1'b1;
      settle();
      check(write_protect_q, 1'b1);
      suspended = 1'b0;
      host.query(8'hd3, b);
      check(b, 8'h00);
      host.unlock(8'h37, 8'h55);
      settle();
      check(write_protect_q, 1'b1);
      host.unlock(8'haa, 8'h37);
      settle();
      check(write_protect_q, 1'b1);
      host.unlock(8'h37, 8'haa);
      settle();
      check(write_protect_q, 1'b0);
      host.query(8'hd3, b);
      check(b, 8'ha2);
   endtask : t_unlock
   initial begin
      #1ms;
      miscompares++;
      wrap_up();
   end
   initial begin
      {miscompares, checks, n_val, n_clr, n_ack, n_int} = '0;
      {ep_stalled, secondary_buf_full, primary_buf_full} = '0;
      {next_toggle, setup_present, host_side_buf_sel} = '0;
      {setup_rx, setup_writing, xact_done, xact_ok, xact_toggle, suspended} = '0;
      {xact_ep, xact_err} = '0;
      rst_b = 1'b0;
      repeat (10) @(posedge core_clk);
      #DLY rst_b = 1'b1;
      t_status();
      t_setup();
      t_outcome();
      t_unlock();
      wrap_up();
   end
endmodule : usb_endpoint_status_error_unlock_test
